// File: src/integer_hw_divider.sv
// sequential signed/unsigned 32-bit divider with operand lock
`timescale 1ns/1ps

// Contract
// - dividend and divisor, 32 bits, software written
// - selectable signed or unsigned operands
// - quotient and remainder in result registers
// - divisor write starts division with held dividend
// - results valid 16 cycles after start
// - operand writes ignored while division runs
// - completion flag and zero divisor flag
// - zero divisor yields zero quotient and remainder
module integer_hw_divider
  import divider_pkg::*;
(
  input  wire logic        sys_clk,        // 100 MHz clock
  input  wire logic        rst,            // synchronous, active high
  input  wire logic        dividend_we,    // write strobe for dividend
  input  wire logic [31:0] dividend_wdata, // dividend value
  input  wire logic        divisor_we,     // write strobe, starts work
  input  wire logic [31:0] divisor_wdata,  // divisor value
  input  wire logic        signed_mode,    // 1: two's complement
  output logic      [31:0] dividend,       // held dividend
  output logic      [31:0] divisor,        // held divisor
  output logic      [31:0] quotient,       // quotient result
  output logic      [31:0] remainder,      // remainder result
  output logic             div_done,       // end of division flag
  output logic             div_zero,       // divisor was zero flag
  output logic             busy            // division in progress
);

  // all state lives in one packed struct, registered in one place
  typedef struct packed {
    // sequencing
    phase_type   phase;
    logic [4:0]  step;
    // software visible registers
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic [31:0] quotient;
    logic [31:0] remainder;
    // iteration working set: operand magnitudes, partial remainder and the two result sign flags
    logic [31:0] den_mag;
    logic [31:0] num_work;
    logic [31:0] rem_work;
    logic        neg_q;
    logic        neg_r;
    // status flags
    logic        done;
    logic        zero;
    logic        busy;
  } state_type;

  state_type cur;       // registered state
  state_type next_cur;  // value for the next edge

  // outputs of the shared iteration stage
  logic [31:0] step_rem;
  logic [31:0] step_num;
  logic [1:0]  step_q;

  // operands as seen by a start in this cycle
  logic [31:0] start_dividend;
  logic        start_neg_num;
  logic        start_neg_den;

  // results of the current iteration, taken in run and fix phases
  logic [31:0] last_quo;
  logic [31:0] last_rem;

  // cycle plan, counted from the edge that takes the divisor write:
  //   edge 0       operands latched, magnitudes formed, busy set
  //   edges 1-15   fifteen two-bit iterations in the run phase
  //   edge 16      sixteenth iteration and sign fix, done set
  // so done is seen one edge after edge 16, and busy stays high for
  // sixteen sampled cycles; folding the sign fix into the last
  // iteration keeps the count at sixteen without a wider stage.
  // limitation: a divide by zero still spends the full sixteen
  // cycles, which keeps timing the same for every operand pair
  // and lets software poll one flag whatever the divisor

  // true when a value is negative under the chosen mode
  function automatic logic is_negative(input logic [31:0] v,
                                       input logic is_signed);
    is_negative = is_signed && v[31];
  endfunction

  // magnitude of a value when treated as signed; the most negative
  // value maps to itself, which read as unsigned is exactly 2**31
  function automatic logic [31:0] magnitude(input logic [31:0] v,
                                            input logic is_signed);
    magnitude = is_negative(v, is_signed) ? (~v + 32'h1) : v;
  endfunction

  // conditional two's complement negate
  function automatic logic [31:0] apply_sign(input logic [31:0] v,
                                             input logic neg);
    apply_sign = neg ? (~v + 32'h1) : v;
  endfunction

  // one shared stage: two quotient bits per clock
  div_step u_step (
    .rem_in  (cur.rem_work),
    .num_in  (cur.num_work),
    .den     (cur.den_mag),
    .rem_out (step_rem),
    .num_out (step_num),
    .qbits   (step_q)
  );

  // a dividend written in the start cycle is the one divided
  assign start_dividend = dividend_we ? dividend_wdata : cur.dividend;
  assign start_neg_num  = is_negative(start_dividend, signed_mode);
  assign start_neg_den  = is_negative(divisor_wdata, signed_mode);

  // quotient bits shift into the freed low end of num_work; the
  // fix phase takes this too, so no iteration is lost to the sign
  assign last_quo = {step_num[31:2], step_q};
  assign last_rem = step_rem;

  // next-state logic for the whole divider
  always_comb begin
    next_cur = cur;
    case (cur.phase)
      st_idle: begin
        // only idle accepts operand writes, so running values hold
        if (dividend_we) begin
          next_cur.dividend = dividend_wdata;
        end
        if (divisor_we) begin
          next_cur.divisor  = divisor_wdata;
          next_cur.phase    = st_run;
          next_cur.step     = 5'h0;
          next_cur.busy     = 1'b1;
          next_cur.done     = 1'b0;
          // zero flag follows every newly written divisor
          next_cur.zero     = (divisor_wdata == 32'h0);
          // signed_mode counts only here; later changes are ignored
          // work on magnitudes; signs are put back at the end
          next_cur.num_work = magnitude(start_dividend, signed_mode);
          next_cur.den_mag  = magnitude(divisor_wdata, signed_mode);
          next_cur.rem_work = 32'h0;
          // remainder follows the dividend, quotient the sign product
          next_cur.neg_r    = start_neg_num;
          next_cur.neg_q    = start_neg_num ^ start_neg_den;
        end
      end
      st_run: begin
        // two more quotient bits per cycle
        next_cur.rem_work = last_rem;
        next_cur.num_work = last_quo;
        next_cur.step     = cur.step + 5'h1;
        // fifteen iterations here; the sixteenth runs in the fix phase
        if (cur.step == STEP_LAST - 5'h1) begin
          next_cur.phase = st_fix;
        end
      end
      st_fix: begin
        // last iteration and sign fix share this cycle
        next_cur.phase    = st_idle;
        next_cur.busy     = 1'b0;
        next_cur.done     = 1'b1;
        next_cur.rem_work = last_rem;
        next_cur.num_work = last_quo;
        if (cur.zero) begin
          // the iteration ran on a zero divisor; its raw result is
          // replaced so software always reads zeros
          next_cur.quotient  = 32'h0;
          next_cur.remainder = 32'h0;
        end else begin
          next_cur.quotient  = apply_sign(last_quo, cur.neg_q);
          next_cur.remainder = apply_sign(last_rem, cur.neg_r);
        end
      end
      default: begin
        // unreachable encoding: fall back to idle
        next_cur.phase = st_idle;
        next_cur.busy  = 1'b0;
      end
    endcase
  end

  // single state register; synchronous reset to the idle values
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // operands come back as OPERAND_RESET, everything else as zero
      cur.phase     <= st_idle;
      cur.step      <= 5'h0;
      cur.dividend  <= OPERAND_RESET;
      cur.divisor   <= OPERAND_RESET;
      cur.quotient  <= 32'h0;
      cur.remainder <= 32'h0;
      cur.den_mag   <= 32'h0;
      cur.num_work  <= 32'h0;
      cur.rem_work  <= 32'h0;
      cur.neg_q     <= 1'b0;
      cur.neg_r     <= 1'b0;
      cur.done      <= 1'b0;
      cur.zero      <= 1'b0;
      cur.busy      <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state flops; software polls div_done
  // operand registers read back
  assign dividend  = cur.dividend;
  assign divisor   = cur.divisor;

  // results, valid while div_done is set
  assign quotient  = cur.quotient;
  assign remainder = cur.remainder;

  // status flags
  assign div_done  = cur.done;
  assign div_zero  = cur.zero;
  assign busy      = cur.busy;

endmodule

// File: src/divider_pkg.sv
// shared constants and types for the integer divider
package divider_pkg;
  localparam int unsigned DATA_WIDTH    = 32;
  localparam int unsigned DIV_CYCLES    = 16;
  localparam int unsigned BITS_PER_STEP = DATA_WIDTH / DIV_CYCLES;
  localparam logic [31:0] OPERAND_RESET = 32'h0000_0000;
  localparam logic [4:0]  STEP_LAST     = 5'h0f;

  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_fix
  } phase_type;
endpackage

// File: src/div_step.sv
// one iteration of restoring division: two quotient bits per cycle
`timescale 1ns/1ps
module div_step
  import divider_pkg::*;
(
  input  wire logic [31:0] rem_in,   // partial remainder
  input  wire logic [31:0] num_in,   // remaining dividend bits
  input  wire logic [31:0] den,      // divisor magnitude
  output logic      [31:0] rem_out,  // next partial remainder
  output logic      [31:0] num_out,  // shifted dividend, low two bits zero
  output logic      [1:0]  qbits     // quotient bits from this step
);
  // two sequential shift-subtract stages, 33-bit to keep the carry
  always_comb begin
    logic [32:0] r;
    logic [31:0] n;
    r = 33'h0;
    n = num_in;
    r[31:0] = rem_in;
    qbits = 2'h0;
    for (int i = 0; i < 2; i++) begin
      r = {r[31:0], n[31]};
      n = {n[30:0], 1'b0};
      if (r >= {1'b0, den}) begin
        r = r - {1'b0, den};
        qbits[1 - i] = 1'b1;
      end
    end
    rem_out = r[31:0];
    num_out = n;
  end
endmodule

// File: bench/divider_monitor.sv
// port assertions for the integer divider
`timescale 1ns/1ps
module divider_monitor (
  input wire logic        sys_clk,        // divider clock
  input wire logic        rst,            // synchronous, active high
  input wire logic        dividend_we,    // dividend write strobe
  input wire logic [31:0] dividend_wdata, // dividend write data
  input wire logic        divisor_we,     // divisor write strobe
  input wire logic [31:0] divisor_wdata,  // divisor write data
  input wire logic [31:0] dividend,       // held dividend
  input wire logic [31:0] divisor,        // held divisor
  input wire logic [31:0] quotient,       // quotient result
  input wire logic [31:0] remainder,      // remainder result
  input wire logic        div_done,       // completion flag
  input wire logic        div_zero,       // zero divisor flag
  input wire logic        busy            // division running
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a start is a divisor write while idle
  wire logic go = divisor_we && !busy;
  AST_GO: assert property (go |=> busy && !div_done)
    else $error("start not taken");
  // busy seen for sixteen cycles, then done with busy low
  AST_LEN: assert property (go |=> busy [*8] ##1 busy [*8] ##1
    (div_done && !busy))
    else $error("wrong division length");
  AST_DVD: assert property (dividend_we && !busy |=>
    dividend == $past(dividend_wdata))
    else $error("dividend not written");
  AST_LKA: assert property (busy |=> $stable(dividend))
    else $error("dividend changed while busy");
  AST_LKB: assert property (busy |=> $stable(divisor))
    else $error("divisor changed while busy");
  AST_ZF: assert property (go |=>
    div_zero == ($past(divisor_wdata) == 32'h0))
    else $error("zero flag wrong");
  AST_ZR: assert property (div_done && div_zero |->
    quotient == 32'h0 && remainder == 32'h0)
    else $error("zero divisor result not zero");
  AST_HOLD: assert property (div_done && !go |=>
    div_done && $stable(quotient) && $stable(remainder))
    else $error("result did not hold");
endmodule
bind integer_hw_divider divider_monitor mon (.sys_clk(sys_clk), .rst(rst),
  .dividend_we(dividend_we), .dividend_wdata(dividend_wdata),
  .divisor_we(divisor_we), .divisor_wdata(divisor_wdata),
  .dividend(dividend), .divisor(divisor), .quotient(quotient),
  .remainder(remainder), .div_done(div_done), .div_zero(div_zero),
  .busy(busy));

// File: bench/integer_hw_divider_tb.sv
// self-checking bench for the integer divider
`timescale 1ns/1ps
module integer_hw_divider_tb;
  logic sys_clk = 0, rst = 1, dividend_we = 0, divisor_we = 0, signed_mode = 0;
  logic [31:0] dividend_wdata = 0, divisor_wdata = 0;
  logic [31:0] dividend, divisor, quotient, remainder;
  logic div_done, div_zero, busy;
  int mismatches = 0, checks = 0, n;
  // rows: dividend, divisor, signed, quotient, remainder
  logic [31:0] rows [6][5] = '{'{32'h64, 32'h7, 32'h0, 32'he, 32'h2},
    '{32'hfffffff9, 32'h2, 32'h0, 32'h7ffffffc, 32'h1},
    '{32'hfffffff9, 32'h2, 32'h1, 32'hfffffffd, 32'hffffffff},
    '{32'h7, 32'hfffffffe, 32'h1, 32'hfffffffd, 32'h1},
    '{32'h80000000, 32'hffffffff, 32'h1, 32'h80000000, 32'h0},
    '{32'h5, 32'h0, 32'h1, 32'h0, 32'h0}};
  integer_hw_divider dut (.sys_clk(sys_clk), .rst(rst),
    .dividend_we(dividend_we), .dividend_wdata(dividend_wdata),
    .divisor_we(divisor_we), .divisor_wdata(divisor_wdata),
    .signed_mode(signed_mode), .dividend(dividend), .divisor(divisor),
    .quotient(quotient), .remainder(remainder), .div_done(div_done),
    .div_zero(div_zero), .busy(busy));
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one division; lk pokes both operands mid-run, which must be dropped
  task automatic op(input logic [31:0] a, b, input logic s, lk);
    @(posedge sys_clk);
    dividend_we <= 1'h1;
    divisor_we <= 1'h1;
    dividend_wdata <= a;
    divisor_wdata <= b;
    signed_mode <= s;
    for (n = 0; n < 40 && !(n > 0 && div_done); n++) begin
      @(posedge sys_clk);
      dividend_we <= lk && n == 3;
      divisor_we <= lk && n == 3;
      dividend_wdata <= ~a;
      divisor_wdata <= ~b;
      #1;
    end
    if (div_done !== 1'b1) begin
      mismatches++;
      end_sim;
    end
  endtask
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk({30'h0, busy, div_done}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      op(rows[i][0], rows[i][1], rows[i][2][0], 1'h0);
      chk(quotient, rows[i][3]);
      chk(remainder, rows[i][4]);
      chk({31'h0, div_zero}, 32'(rows[i][1] == 32'h0));
      chk(32'(n), 32'h11);
      $display("test %0d done", i);
    end
    // operand writes in mid-run must not disturb the result
    op(32'h64, 32'h7, 1'h0, 1'h1);
    chk(quotient, 32'he);
    chk(divisor, 32'h7);
    chk(dividend, 32'h64);
    $display("lock test done");
    // reset in mid-run drops the division
    @(posedge sys_clk);
    divisor_we <= 1'h1;
    @(posedge sys_clk);
    divisor_we <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'h1;
    @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk({30'h0, busy, div_done}, 32'h0);
    chk(quotient, 32'h0);
    chk(divisor, 32'h0);
    // first division after the mid-run reset must work normally
    op(32'hfffffff9, 32'h2, 1'h1, 1'h0);
    chk(quotient, 32'hfffffffd);
    chk(remainder, 32'hffffffff);
    chk(32'(n), 32'h11);
    $display("reset test done");
    end_sim;
  end
endmodule
